// *** rtl/dbe_consts.svh ***
// Offsets, field positions and reset values of the debug interrupt entry block
`ifndef DBE_CONSTS_SVH
`define DBE_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DBE_ADDR_STATUS     12'h000
`define DBE_ADDR_CONTROL0   12'h004
`define DBE_ADDR_MSTATE     12'h008
`define DBE_ADDR_VPREFIX    12'h00c
`define DBE_ADDR_VOFFSET    12'h010
`define DBE_ADDR_SAVECFG    12'h014
`define DBE_ADDR_DSAVE_PC   12'h018
`define DBE_ADDR_DSAVE_ST   12'h01c
`define DBE_ADDR_CSAVE_PC   12'h020
`define DBE_ADDR_CSAVE_ST   12'h024

// ****************************************************************
// Status syndrome bits (control0 enables share the layout)
// ****************************************************************
`define DBE_ST_UNCOND       0
`define DBE_ST_INSTR_COMPLETE_EVENT         1
`define DBE_ST_BRANCH       2
`define DBE_ST_IRQ          3
`define DBE_ST_CIRQ         4
`define DBE_ST_TRAP         5
`define DBE_ST_IAM_LO       6
`define DBE_ST_DAC_LO       10
`define DBE_ST_RET          14
`define DBE_ST_CRIT_INTERRUPT_EXIT_EVENT         15
`define DBE_ST_DBG_COUNTER_EVENT_LO      16
`define DBE_ST_EXT          18
`define DBE_ST_IMPRECISE    19
`define DBE_ST_MASK         32'h0007_ffff
`define DBE_CTL_IDM         31
`define DBE_CFG_SAVE_EN     0

// ****************************************************************
// Machine state bits
// ****************************************************************
`define DBE_MS_UCLE         26
`define DBE_MS_SPE          25
`define DBE_MS_WE           18
`define DBE_MS_CE           17
`define DBE_MS_EE           15
`define DBE_MS_PR           14
`define DBE_MS_FP           13
`define DBE_MS_ME           12
`define DBE_MS_FE0          11
`define DBE_MS_DE           9
`define DBE_MS_FE1          8
`define DBE_MS_IS           5
`define DBE_MS_DS           4
`define DBE_MS_RI           1

// ****************************************************************
// Reset values and vector fields
// ****************************************************************
`define DBE_RST_WORD        32'h0000_0000
`define DBE_VEC_LOW         4'h0

`endif

// *** rtl/dbe_pkg.sv ***
// Types shared by the debug interrupt entry block
package dbe_pkg;

  // One-cycle event strobes from pipeline, interrupt sequencer and counters
  typedef struct packed {
    logic       instr_complete_event;
    logic       branch_taken_event;
    logic       irq_taken_event;
    logic       crit_irq_taken_event;
    logic       trap_event;
    logic [3:0] instr_addr_match;
    logic [3:0] data_addr_match;
    logic       interrupt_exit_event;
    logic       crit_interrupt_exit_event;
    logic [1:0] dbg_counter_event;
  } dbe_evt_s;

  typedef struct packed {
    logic [31:0] cur_pc;
    logic [31:0] next_pc;
    logic [31:0] resume_pc;
    logic [31:0] irq_handler_pc;
    logic [31:0] crit_handler_pc;
  } dbe_pcs_s;

  typedef enum logic [2:0] {
    DBE_PC_CUR,
    DBE_PC_NEXT,
    DBE_PC_IRQ,
    DBE_PC_CIRQ,
    DBE_PC_RESUME
  } dbe_pcsel_e;

endpackage

// *** rtl/dbe_debug_entry.sv ***
// Debug event detection, status syndrome and debug interrupt entry
`timescale 1ns/1ps
`include "dbe_consts.svh"

module dbe_debug_entry (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [11:0]      i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic [31:0]           o_prdata,
  output logic                  o_pslverr,
  input  wire dbe_pkg::dbe_evt_s i_evt,
  input  wire dbe_pkg::dbe_pcs_s i_pcs,
  input  wire logic             i_higher_pend,
  input  wire logic             i_uncond_dbg_in,
  input  wire logic             i_ext_dbg_in1,
  input  wire logic             i_ext_dbg_in2,
  output logic                  o_dbg_take,
  output logic [31:0]           o_dbg_vector,
  output logic [31:0]           o_machine_state
);
  import dbe_pkg::*;

  logic [31:0] dbg_status_reg;
  logic [31:0] dbg_control0_reg;
  logic [31:0] machine_state_reg;
  logic [31:0] vector_prefix_reg;
  logic [31:0] dbg_vector_offset;
  logic [31:0] save_cfg_reg;
  logic [31:0] dbg_save_pc;
  logic [31:0] dbg_save_state;
  logic [31:0] crit_save_pc;
  logic [31:0] crit_save_state;
  logic [31:0] prdata_reg;
  logic        take_reg;
  logic [31:0] vector_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [31:0] raw_evt;
  logic [31:0] new_evt;
  logic [31:0] status_next;
  logic        dbg_enable;
  logic        take_now;
  logic        save_en;
  logic        wr_access;
  logic        rd_setup;
  logic        addr_hit;
  logic [31:0] entry_state;
  logic [31:0] save_pc_next;
  dbe_pcsel_e  pc_sel;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `DBE_ADDR_STATUS) || (a == `DBE_ADDR_CONTROL0) || (a == `DBE_ADDR_MSTATE) ||
             (a == `DBE_ADDR_VPREFIX) || (a == `DBE_ADDR_VOFFSET) || (a == `DBE_ADDR_SAVECFG) ||
             (a == `DBE_ADDR_DSAVE_PC) || (a == `DBE_ADDR_DSAVE_ST) ||
             (a == `DBE_ADDR_CSAVE_PC) || (a == `DBE_ADDR_CSAVE_ST);
  endfunction

  function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] off, input logic acc);
    wr_hit = acc && (a == off);
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign addr_hit  = mapped(i_paddr);
  assign wr_access = i_psel && i_penable && i_pwrite && addr_hit;
  assign rd_setup  = i_psel && !i_penable && !i_pwrite;
  // Zero wait states keep the slave trivially ordered against event logic
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata  = prdata_reg;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      prdata_reg <= `DBE_RST_WORD;
    else if (rd_setup)
    begin
      unique case (i_paddr)
        `DBE_ADDR_STATUS:   prdata_reg <= dbg_status_reg;
        `DBE_ADDR_CONTROL0: prdata_reg <= dbg_control0_reg;
        `DBE_ADDR_MSTATE:   prdata_reg <= machine_state_reg;
        `DBE_ADDR_VPREFIX:  prdata_reg <= vector_prefix_reg;
        `DBE_ADDR_VOFFSET:  prdata_reg <= dbg_vector_offset;
        `DBE_ADDR_SAVECFG:  prdata_reg <= save_cfg_reg;
        `DBE_ADDR_DSAVE_PC: prdata_reg <= dbg_save_pc;
        `DBE_ADDR_DSAVE_ST: prdata_reg <= dbg_save_state;
        `DBE_ADDR_CSAVE_PC: prdata_reg <= crit_save_pc;
        `DBE_ADDR_CSAVE_ST: prdata_reg <= crit_save_state;
        default:            prdata_reg <= `DBE_RST_WORD;
      endcase
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {i_ext_dbg_in2, i_ext_dbg_in1, i_uncond_dbg_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ****************************************************************
  // Event detection
  // ****************************************************************
  always_comb
  begin
    raw_evt                                   = `DBE_RST_WORD;
    raw_evt[`DBE_ST_UNCOND]                   = sync2_reg[0] && !sync3_reg[0];
    raw_evt[`DBE_ST_INSTR_COMPLETE_EVENT]                     = i_evt.instr_complete_event;
    raw_evt[`DBE_ST_BRANCH]                   = i_evt.branch_taken_event;
    raw_evt[`DBE_ST_IRQ]                      = i_evt.irq_taken_event;
    raw_evt[`DBE_ST_CIRQ]                     = i_evt.crit_irq_taken_event;
    raw_evt[`DBE_ST_TRAP]                     = i_evt.trap_event;
    raw_evt[`DBE_ST_IAM_LO+3:`DBE_ST_IAM_LO]  = i_evt.instr_addr_match;
    raw_evt[`DBE_ST_DAC_LO+3:`DBE_ST_DAC_LO]  = i_evt.data_addr_match;
    raw_evt[`DBE_ST_RET]                      = i_evt.interrupt_exit_event;
    raw_evt[`DBE_ST_CRIT_INTERRUPT_EXIT_EVENT]                     = i_evt.crit_interrupt_exit_event;
    raw_evt[`DBE_ST_DBG_COUNTER_EVENT_LO+1:`DBE_ST_DBG_COUNTER_EVENT_LO] = i_evt.dbg_counter_event;
    raw_evt[`DBE_ST_EXT]                      = (sync2_reg[1] && !sync3_reg[1]) ||
                                                (sync2_reg[2] && !sync3_reg[2]);
  end

  // Unconditional source needs no enable
  assign new_evt    = raw_evt & (dbg_control0_reg | (32'h1 << `DBE_ST_UNCOND)) & `DBE_ST_MASK;
  assign dbg_enable = machine_state_reg[`DBE_MS_DE] && dbg_control0_reg[`DBE_CTL_IDM];
  // Recorded events also fire once enables come up, covering the delayed case
  assign take_now   = dbg_enable && !i_higher_pend && !take_reg &&
                      (|new_evt || |(dbg_status_reg & `DBE_ST_MASK));
  assign save_en    = save_cfg_reg[`DBE_CFG_SAVE_EN];

  // ****************************************************************
  // Status syndrome
  // ****************************************************************
  always_comb
  begin
    status_next = dbg_status_reg;
    if (wr_hit(i_paddr, `DBE_ADDR_STATUS, wr_access))
      status_next = status_next & ~i_pwdata;
    // Set beats a simultaneous write-one-to-clear
    status_next = status_next | new_evt;
    if (|new_evt && !machine_state_reg[`DBE_MS_DE])
      status_next[`DBE_ST_IMPRECISE] = 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      dbg_status_reg <= `DBE_RST_WORD;
    else
      dbg_status_reg <= status_next;
  end

  // ****************************************************************
  // Resume address selection
  // ****************************************************************
  always_comb
  begin
    if (|new_evt[`DBE_ST_CRIT_INTERRUPT_EXIT_EVENT:`DBE_ST_RET] || |new_evt[`DBE_ST_IAM_LO+3:`DBE_ST_IAM_LO] ||
        new_evt[`DBE_ST_BRANCH] || new_evt[`DBE_ST_TRAP])
      pc_sel = DBE_PC_CUR;
    else if (|new_evt[`DBE_ST_DAC_LO+3:`DBE_ST_DAC_LO] || new_evt[`DBE_ST_INSTR_COMPLETE_EVENT])
      pc_sel = DBE_PC_NEXT;
    else if (new_evt[`DBE_ST_IRQ])
      pc_sel = DBE_PC_IRQ;
    else if (new_evt[`DBE_ST_CIRQ])
      pc_sel = DBE_PC_CIRQ;
    else
      pc_sel = DBE_PC_RESUME;
    unique case (pc_sel)
      DBE_PC_CUR:    save_pc_next = i_pcs.cur_pc;
      DBE_PC_NEXT:   save_pc_next = i_pcs.next_pc;
      DBE_PC_IRQ:    save_pc_next = i_pcs.irq_handler_pc;
      DBE_PC_CIRQ:   save_pc_next = i_pcs.crit_handler_pc;
      DBE_PC_RESUME: save_pc_next = i_pcs.resume_pc;
      default:       save_pc_next = i_pcs.resume_pc;
    endcase
  end

  // ****************************************************************
  // Machine state on entry
  // ****************************************************************
  always_comb
  begin
    entry_state = machine_state_reg;
    entry_state[`DBE_MS_UCLE] = 1'b0;
    entry_state[`DBE_MS_SPE]  = 1'b0;
    entry_state[`DBE_MS_WE]   = 1'b0;
    entry_state[`DBE_MS_PR]   = 1'b0;
    entry_state[`DBE_MS_FP]   = 1'b0;
    entry_state[`DBE_MS_FE0]  = 1'b0;
    entry_state[`DBE_MS_FE1]  = 1'b0;
    entry_state[`DBE_MS_DE]   = 1'b0;
    entry_state[`DBE_MS_IS]   = 1'b0;
    entry_state[`DBE_MS_DS]   = 1'b0;
    // Critical-class bits only fall when critical save registers are consumed
    if (!save_en)
    begin
      entry_state[`DBE_MS_CE] = 1'b0;
      entry_state[`DBE_MS_EE] = 1'b0;
      entry_state[`DBE_MS_RI] = 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      machine_state_reg <= `DBE_RST_WORD;
    else if (take_now)
      machine_state_reg <= entry_state;
    else if (wr_hit(i_paddr, `DBE_ADDR_MSTATE, wr_access))
      machine_state_reg <= i_pwdata;
  end

  // ****************************************************************
  // Software control registers
  // ****************************************************************
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      dbg_control0_reg  <= `DBE_RST_WORD;
      vector_prefix_reg <= `DBE_RST_WORD;
      dbg_vector_offset <= `DBE_RST_WORD;
      save_cfg_reg      <= `DBE_RST_WORD;
    end
    else
    begin
      if (wr_hit(i_paddr, `DBE_ADDR_CONTROL0, wr_access))
        dbg_control0_reg <= i_pwdata;
      if (wr_hit(i_paddr, `DBE_ADDR_VPREFIX, wr_access))
        vector_prefix_reg <= {i_pwdata[31:16], 16'h0000};
      if (wr_hit(i_paddr, `DBE_ADDR_VOFFSET, wr_access))
        dbg_vector_offset <= {16'h0000, i_pwdata[15:4], 4'h0};
      if (wr_hit(i_paddr, `DBE_ADDR_SAVECFG, wr_access))
        save_cfg_reg <= {31'h0, i_pwdata[`DBE_CFG_SAVE_EN]};
    end
  end

  // ****************************************************************
  // Save registers, take pulse and vector
  // ****************************************************************
  // No path exists to exception syndrome, machine check syndrome or data address
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      dbg_save_pc     <= `DBE_RST_WORD;
      dbg_save_state  <= `DBE_RST_WORD;
      crit_save_pc    <= `DBE_RST_WORD;
      crit_save_state <= `DBE_RST_WORD;
    end
    else if (take_now && save_en)
    begin
      dbg_save_pc    <= save_pc_next;
      dbg_save_state <= machine_state_reg;
    end
    else if (take_now)
    begin
      crit_save_pc    <= save_pc_next;
      crit_save_state <= machine_state_reg;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      take_reg   <= 1'b0;
      vector_reg <= `DBE_RST_WORD;
    end
    else
    begin
      take_reg <= take_now;
      if (take_now)
        vector_reg <= {vector_prefix_reg[31:16], dbg_vector_offset[15:4], `DBE_VEC_LOW};
    end
  end

  assign o_dbg_take      = take_reg;
  assign o_dbg_vector    = vector_reg;
  assign o_machine_state = machine_state_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_instr_complete_event_sets_flag: assert property (i_evt.instr_complete_event && dbg_control0_reg[`DBE_ST_INSTR_COMPLETE_EVENT]
    |=> dbg_status_reg[`DBE_ST_INSTR_COMPLETE_EVENT]) else $error("instr_complete_event flag missing");
  a_uncond_edge: assert property ($rose(sync2_reg[0]) |=> dbg_status_reg[`DBE_ST_UNCOND])
    else $error("unconditional flag missing");
  a_ext_edge_flag: assert property (dbg_control0_reg[`DBE_ST_EXT] && $rose(sync2_reg[1])
    |=> dbg_status_reg[`DBE_ST_EXT]) else $error("external flag missing");
  a_imprecise_flag: assert property (|new_evt && !machine_state_reg[`DBE_MS_DE]
    |=> dbg_status_reg[`DBE_ST_IMPRECISE] && !o_dbg_take) else $error("imprecise not recorded");
  a_no_take_higher: assert property (i_higher_pend |=> !o_dbg_take)
    else $error("took under higher priority");
  a_state_saved: assert property (take_now && save_en |=> dbg_save_state == $past(machine_state_reg))
    else $error("saved state wrong");
  a_entry_clears: assert property (o_dbg_take |-> !machine_state_reg[`DBE_MS_DE] &&
    !machine_state_reg[`DBE_MS_PR] && machine_state_reg[`DBE_MS_ME] == $past(machine_state_reg[`DBE_MS_ME]))
    else $error("entry state wrong");
  a_vector_form: assert property (o_dbg_take |-> o_dbg_vector[3:0] == 4'h0 &&
    o_dbg_vector[31:16] == vector_prefix_reg[31:16]) else $error("vector wrong");
  a_instr_complete_event_next_pc: assert property (take_now && save_en && new_evt == (32'h1 << `DBE_ST_INSTR_COMPLETE_EVENT)
    |=> dbg_save_pc == $past(i_pcs.next_pc)) else $error("instr_complete_event resume address wrong");
  a_delayed_take: assert property (!take_reg && dbg_enable && !i_higher_pend &&
    |(dbg_status_reg & `DBE_ST_MASK) |=> o_dbg_take) else $error("recorded event not delivered");

  c_take_dbg_save:  cover property (take_now && save_en);
  c_take_crit_save: cover property (take_now && !save_en);
  c_delayed_entry:  cover property (!machine_state_reg[`DBE_MS_DE] ##1 dbg_enable ##1 o_dbg_take);
  c_ext_event:      cover property (new_evt[`DBE_ST_EXT]);

endmodule

// *** verif/dbe_ext_dbg_model.sv ***
// External debug partner driving the unconditional and external event pins
`timescale 1ns/1ps
// ****************************************************************
// Pin driver
// ****************************************************************
module dbe_ext_dbg_model (
  input  wire logic       i_mclk,
  input  wire logic [2:0] i_req,
  output logic            o_uncond,
  output logic            o_ext1,
  output logic            o_ext2
);
  // Pins move only after a core edge; a level held high is one event
  always_ff @(posedge i_mclk)
  begin
    o_uncond <= i_req[0];
    o_ext1   <= i_req[1];
    o_ext2   <= i_req[2];
  end
endmodule

// *** verif/test_debug_interrupt_entry.sv ***
// Self-checking bench for the debug interrupt entry block
`timescale 1ns/1ps
`include "dbe_consts.svh"
module test_debug_interrupt_entry;
  import dbe_pkg::*;
  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  dbe_evt_s    evt = '0;
  dbe_pcs_s    pcs = '{32'h0000_1000, 32'h0000_1004, 32'h0000_2000, 32'h0000_3000, 32'h0000_4000};
  logic        hpend = 1'b0;
  logic [2:0]  req = 3'h0;
  logic        uncond;
  logic        ext1;
  logic        ext2;
  logic        take;
  logic [31:0] vec;
  logic [31:0] mstate;
  logic [31:0] rd;
  logic        err;
  logic        got;
  logic [31:0] vec_s;
  logic [31:0] ms_s;
  int          mismatches = 0;
  int          compares = 0;
  // Event bit in the strobe struct, status bit, expected saved address
  int          eb_t [15] = '{8, 11, 15, 12, 3, 2, 4, 7, 14, 13, 1, 16, 0, 0, 0};
  int          st_t [15] = '{6, 9, 2, 5, 14, 15, 10, 13, 3, 4, 17, 1, 0, 18, 18};
  logic [31:0] pc_t [15] = '{32'h0000_1000, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000, 32'h0000_1000,
                             32'h0000_1000, 32'h0000_1004, 32'h0000_1004, 32'h0000_3000, 32'h0000_4000,
                             32'h0000_2000, 32'h0000_1004, 32'h0000_2000, 32'h0000_2000, 32'h0000_2000};

  always #12.5 mclk = ~mclk;

  dbe_debug_entry u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_evt(evt), .i_pcs(pcs), .i_higher_pend(hpend), .i_uncond_dbg_in(uncond), .i_ext_dbg_in1(ext1),
    .i_ext_dbg_in2(ext2), .o_dbg_take(take), .o_dbg_vector(vec), .o_machine_state(mstate));

  dbe_ext_dbg_model u_ext (.i_mclk(mclk), .i_req(req), .o_uncond(uncond), .o_ext1(ext1), .o_ext2(ext2));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Ready, read data and error are all taken at the rising edge that completes the access
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input dbe_evt_s e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
  endtask

  task automatic wait_take(input int n);
    got = 1'b0;
    repeat (n)
    begin
      @(negedge mclk);
      if (take === 1'b1)
      begin
        got = 1'b1;
        vec_s = vec;
        ms_s = mstate;
        break;
      end
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_check();
    for (int a = 0; a < 40; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0000_0000);
      chk(rd, 32'h0000_0000, "reset value");
    end
    apb(1'b1, `DBE_ADDR_DSAVE_PC, 32'hffff_ffff);
    apb(1'b0, `DBE_ADDR_DSAVE_PC, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "read-only save pc");
    apb(1'b0, 12'h028, 32'h0000_0000);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
  endtask

  // Fifteen sources in turn (address-match lanes 0 and 3, counter event 1 only), alternating debug and critical save registers
  task automatic do_take(input int k);
    logic        cfg;
    logic [31:0] exp_ms;
    // Odd sources, critical-taken among them, run with debug save registers on
    cfg = k[0];
    exp_ms = cfg ? 32'h0002_9002 : 32'h0000_1000;
    apb(1'b1, `DBE_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b1, `DBE_ADDR_SAVECFG, {31'h0, cfg});
    apb(1'b1, `DBE_ADDR_MSTATE, 32'h0406_f222);
    if (k < 12)
      pulse(dbe_evt_s'(17'h1 << eb_t[k]));
    else
      req <= 3'(1 << (k - 12));
    wait_take(30);
    chk({31'h0, got}, 32'h1, "take");
    chk(vec_s, 32'hab12_0f70, "vector");
    chk(ms_s, exp_ms, "entry state");
    apb(1'b0, cfg ? `DBE_ADDR_DSAVE_PC : `DBE_ADDR_CSAVE_PC, 32'h0000_0000);
    chk(rd, pc_t[k], "saved pc");
    apb(1'b0, cfg ? `DBE_ADDR_DSAVE_ST : `DBE_ADDR_CSAVE_ST, 32'h0000_0000);
    chk(rd, 32'h0406_f222, "saved state");
    apb(1'b0, `DBE_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h1 << st_t[k], "syndrome");
    req <= 3'h0;
  endtask

  // Event while debug disabled, then delivered once enabled
  task automatic delayed_take();
    apb(1'b1, `DBE_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b1, `DBE_ADDR_SAVECFG, 32'h0000_0001);
    apb(1'b1, `DBE_ADDR_MSTATE, 32'h0000_0000);
    pulse(dbe_evt_s'(17'h1 << 15));
    wait_take(10);
    chk({31'h0, got}, 32'h0, "take while disabled");
    apb(1'b0, `DBE_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0008_0004, "imprecise record");
    apb(1'b1, `DBE_ADDR_MSTATE, 32'h0000_0200);
    wait_take(10);
    chk({31'h0, got}, 32'h1, "delayed take");
    apb(1'b0, `DBE_ADDR_DSAVE_PC, 32'h0000_0000);
    chk(rd, 32'h0000_2000, "delayed pc");
  endtask

  // A pending higher exception holds the take back
  task automatic pend_take();
    apb(1'b1, `DBE_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b1, `DBE_ADDR_MSTATE, 32'h0000_0200);
    hpend <= 1'b1;
    pulse(dbe_evt_s'(17'h1 << 12));
    wait_take(10);
    chk({31'h0, got}, 32'h0, "take while pending");
    @(posedge mclk);
    hpend <= 1'b0;
    wait_take(10);
    chk({31'h0, got}, 32'h1, "take after pending");
    apb(1'b0, `DBE_ADDR_DSAVE_PC, 32'h0000_0000);
    chk(rd, 32'h0000_2000, "pending pc");
  endtask

  // Disabled source and cleared internal mode both hold the take back
  task automatic mask_take();
    apb(1'b1, `DBE_ADDR_CONTROL0, 32'h8007_fffc);
    apb(1'b1, `DBE_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b1, `DBE_ADDR_MSTATE, 32'h0000_0200);
    pulse(dbe_evt_s'(17'h1 << 16));
    wait_take(10);
    chk({31'h0, got}, 32'h0, "take for disabled source");
    apb(1'b0, `DBE_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "disabled source flag");
    apb(1'b1, `DBE_ADDR_CONTROL0, 32'h0007_fffe);
    pulse(dbe_evt_s'(17'h1 << 16));
    wait_take(10);
    chk({31'h0, got}, 32'h0, "take without internal mode");
    apb(1'b0, `DBE_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "recorded without internal mode");
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    reset_check();
    apb(1'b1, `DBE_ADDR_CONTROL0, 32'h8007_fffe);
    apb(1'b1, `DBE_ADDR_VPREFIX, 32'hab12_3456);
    apb(1'b1, `DBE_ADDR_VOFFSET, 32'h0000_0f70);
    for (int k = 0; k < 15; k++)
      do_take(k);
    delayed_take();
    pend_take();
    mask_take();
    finish_test();
  end
endmodule
